// *** logic/operand_addressing_unit.sv ***
// Operand addressing unit with program counter and register bus
// Operation
// - High program counter byte is its own register, zero after reset.
// - Low program counter byte is its own register, zero after reset.
// - Source immediate: operand byte is source; result to A, F, SP or X.
// - Source immediate arithmetic takes the selected A, X, F or SP as second input.
// - Source direct: operand addresses RAM or register space; result to A or X.
// - Source indexed: address is operand plus X; result to A or X.
// - Destination direct: operand addresses result; A or X is source.
// - Writing to memory leaves the accumulator unchanged.
// - Destination indexed: address is operand plus X; source is A.
// - Destination indexed arithmetic reads and rewrites that same location.
// - Direct with immediate: first operand addresses, second is source.
// - The five single operand modes take two instruction bytes.
// - Direct with immediate takes three instruction bytes.
// - Register space marked operands reach peripheral space at same address.
// - AND into flags combines immediate with flags and writes flags.
// - Flags bank bit chooses register bank zero or one.
`timescale 1ns/100ps
`default_nettype none
module operand_addressing_unit
   import opaddr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   // Register bus
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // Instruction fetch
   output logic [15:0] fetchAddr,
   output logic fetchReq,
   input wire logic [7:0] fetchData,
   input wire logic fetchAck,
   // Data memory and register space
   output logic [7:0] memAddr,
   output logic memRegSpace,
   output logic memBank,
   output logic memRe,
   output logic memWe,
   output logic [7:0] memWrData,
   input wire logic [7:0] memRdData,
   input wire logic memAck
);

   // ==========================================================
   // State
   state_t stateFf;
   logic [7:0] pcLowFf;
   logic [7:0] pcHighFf;
   logic [7:0] accFf;
   logic [7:0] indexFf;
   logic [7:0] flagsFf;
   logic [7:0] stackFf;
   logic [7:0] opcodeFf;
   logic [7:0] opnd1Ff;
   logic [7:0] opnd2Ff;
   logic [7:0] readFf;
   logic runFf;
   logic illegalFf;
   logic wbAckFf;
   logic [31:0] wbDatRFf;
   logic fetchReqFf;
   logic [7:0] memAddrFf;
   logic memRegSpaceFf;
   logic memBankFf;
   logic memReFf;
   logic memWeFf;
   logic [7:0] memWrDataFf;

   // ==========================================================
   // Opcode field decode
   addr_mode_t mode;
   reg_sel_t regSel;
   alu_op_t aluOp;
   logic spaceBit;
   assign mode = addr_mode_t'(opcodeFf[OPC_MODE_LSB +: 3]);
   assign regSel = reg_sel_t'(opcodeFf[OPC_SEL_LSB +: 2]);
   assign aluOp = alu_op_t'(opcodeFf[OPC_ALU_LSB +: 2]);
   assign spaceBit = opcodeFf[OPC_SPACE_BIT];

   // Result lands in memory for the destination modes
   function automatic logic isMemDest(input addr_mode_t m);
      isMemDest = (m == MODE_DST_DIR) || (m == MODE_DST_IDX) || (m == MODE_DST_DIR_IMM);
   endfunction

   // Mode is one of the six handled here
   function automatic logic isKnown(input addr_mode_t m);
      isKnown = (m != MODE_RSV6) && (m != MODE_RSV7);
   endfunction

   // ==========================================================
   // Mode dependent decode
   logic memDest;
   logic knownMode;
   logic threeByte;
   logic needRead;
   logic useIndex;
   logic [7:0] selAX;
   logic [7:0] selReg;
   assign memDest = isMemDest(mode);
   assign knownMode = isKnown(mode);
   assign threeByte = (mode == MODE_DST_DIR_IMM);
   // Destination arithmetic also reads the result location
   assign needRead = (mode == MODE_SRC_DIR) || (mode == MODE_SRC_IDX) ||
                     (memDest && (aluOp != ALU_MOV));
   assign useIndex = (mode == MODE_SRC_IDX) || (mode == MODE_DST_IDX);
   assign selAX = regSel[0] ? indexFf : accFf;
   assign selReg = (regSel == SEL_FLAGS) ? flagsFf :
                   (regSel == SEL_STACK) ? stackFf : selAX;

   // Source and second input per mode
   logic [7:0] srcVal;
   logic [7:0] otherVal;
   assign srcVal = (mode == MODE_SRC_IMM) ? opnd1Ff :
                   (mode == MODE_DST_DIR_IMM) ? opnd2Ff :
                   (mode == MODE_DST_IDX) ? accFf :
                   (mode == MODE_DST_DIR) ? selAX : readFf;
   assign otherVal = memDest ? readFf :
                     (mode == MODE_SRC_IMM) ? selReg : selAX;

   // ==========================================================
   // Address former and operation unit
   logic [7:0] opAddr;
   logic opRegSpace;
   logic opBank;
   logic [7:0] aluResult;

   operand_addr_gen u_addr (
      .operand(opnd1Ff),
      .indexVal(indexFf),
      .useIndex(useIndex),
      .spaceSel(spaceBit),
      .flagsVal(flagsFf),
      .addr(opAddr),
      .regSpace(opRegSpace),
      .bank(opBank)
   );

   alu8 u_alu (
      .op(aluOp),
      .srcVal(srcVal),
      .otherVal(otherVal),
      .result(aluResult)
   );

   // ==========================================================
   // Program counter step
   logic [15:0] pcNext;
   assign pcNext = {pcHighFf, pcLowFf} + PC_STEP;

   // Register result write enables
   logic execReg;
   logic wrAcc;
   logic wrIndex;
   logic wrFlags;
   logic wrStack;
   assign execReg = (stateFf == ST_EXEC) && !memDest;
   assign wrAcc = execReg && (regSel == SEL_ACC || mode != MODE_SRC_IMM) && !regSel[0];
   assign wrIndex = execReg && regSel[0] && (regSel == SEL_INDEX || mode != MODE_SRC_IMM);
   assign wrFlags = execReg && (mode == MODE_SRC_IMM) && (regSel == SEL_FLAGS);
   assign wrStack = execReg && (mode == MODE_SRC_IMM) && (regSel == SEL_STACK);

   // ==========================================================
   // Instruction sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stateFf <= ST_IDLE;
         pcLowFf <= PC_BYTE_RST;
         pcHighFf <= PC_BYTE_RST;
         opcodeFf <= DATA_RST;
         opnd1Ff <= DATA_RST;
         opnd2Ff <= DATA_RST;
         readFf <= DATA_RST;
         fetchReqFf <= 1'b0;
         memAddrFf <= DATA_RST;
         memRegSpaceFf <= 1'b0;
         memBankFf <= 1'b0;
         memReFf <= 1'b0;
         memWeFf <= 1'b0;
         memWrDataFf <= DATA_RST;
      end else begin
         case (stateFf)
            ST_IDLE: begin
               if (runFf) begin
                  fetchReqFf <= 1'b1;
                  stateFf <= ST_OPCODE;
               end
            end
            ST_OPCODE: begin
               if (fetchAck) begin
                  opcodeFf <= fetchData;
                  {pcHighFf, pcLowFf} <= pcNext;
                  stateFf <= ST_OPND1;
               end
            end
            ST_OPND1: begin
               if (!knownMode) begin
                  fetchReqFf <= 1'b0;
                  stateFf <= ST_IDLE;
               end else if (fetchAck) begin
                  opnd1Ff <= fetchData;
                  {pcHighFf, pcLowFf} <= pcNext;
                  fetchReqFf <= threeByte;
                  stateFf <= threeByte ? ST_OPND2 :
                             (mode == MODE_SRC_IMM) ? ST_EXEC : ST_ADDR;
               end
            end
            ST_OPND2: begin
               if (fetchAck) begin
                  opnd2Ff <= fetchData;
                  {pcHighFf, pcLowFf} <= pcNext;
                  fetchReqFf <= 1'b0;
                  stateFf <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               memAddrFf <= opAddr;
               memRegSpaceFf <= opRegSpace;
               memBankFf <= opBank;
               memReFf <= needRead;
               stateFf <= needRead ? ST_READ : ST_EXEC;
            end
            ST_READ: begin
               if (memAck) begin
                  readFf <= memRdData;
                  memReFf <= 1'b0;
                  stateFf <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (memDest) begin
                  memWrDataFf <= aluResult; // Same location written back
                  memWeFf <= 1'b1;
                  stateFf <= ST_WRITE;
               end else begin
                  stateFf <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (memAck) begin
                  memWeFf <= 1'b0;
                  stateFf <= ST_IDLE;
               end
            end
            default: begin
               stateFf <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Core data registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accFf <= DATA_RST;
         indexFf <= DATA_RST;
         flagsFf <= FLAGS_RST;
         stackFf <= DATA_RST;
      end else begin
         if (wrAcc) accFf <= aluResult;
         if (wrIndex) indexFf <= aluResult;
         if (wrFlags) flagsFf <= (aluResult & FLAGS_WR_MASK) | (flagsFf & ~FLAGS_WR_MASK);
         if (wrStack) stackFf <= aluResult;
      end
   end

   // ==========================================================
   // Register bus decode
   logic busReq;
   logic busWr;
   logic ctrlWr;
   logic illegalSet;
   logic [31:0] rdMux;
   assign busReq = wbCyc && wbStb && !wbAckFf;
   assign busWr = wbCyc && wbStb && wbWe && wbAckFf; // Write lands on the edge that sees ack
   assign ctrlWr = busWr && (wbAdr == ADR_CTRL) && wbSel[0];
   assign illegalSet = (stateFf == ST_OPND1) && !knownMode;
   assign rdMux = (wbAdr == ADR_PC_LOW) ? {24'h000000, pcLowFf} :
                  (wbAdr == ADR_PC_HIGH) ? {24'h000000, pcHighFf} :
                  (wbAdr == ADR_CTRL) ? {31'h00000000, runFf} :
                  (wbAdr == ADR_STATUS) ? {28'h0000000, illegalFf, stateFf} :
                  (wbAdr == ADR_ACC) ? {24'h000000, accFf} :
                  (wbAdr == ADR_INDEX) ? {24'h000000, indexFf} :
                  (wbAdr == ADR_FLAGS) ? {24'h000000, flagsFf} :
                  (wbAdr == ADR_STACK) ? {24'h000000, stackFf} : 32'h00000000;

   // Bus answer, control and sticky status
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wbAckFf <= 1'b0;
         wbDatRFf <= 32'h00000000;
         runFf <= 1'b0;
         illegalFf <= 1'b0;
      end else begin
         wbAckFf <= busReq;
         if (busReq && !wbWe) wbDatRFf <= rdMux;
         if (ctrlWr) runFf <= wbDatW[CTRL_RUN_BIT];
         if (illegalSet) illegalFf <= 1'b1; // Set wins over clear
         else if (ctrlWr && wbDatW[CTRL_CLR_ILL_BIT]) illegalFf <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops
   assign wbAck = wbAckFf;
   assign wbDatR = wbDatRFf;
   assign fetchAddr = {pcHighFf, pcLowFf};
   assign fetchReq = fetchReqFf;
   assign memAddr = memAddrFf;
   assign memRegSpace = memRegSpaceFf;
   assign memBank = memBankFf;
   assign memRe = memReFf;
   assign memWe = memWeFf;
   assign memWrData = memWrDataFf;

endmodule // operand_addressing_unit
`default_nettype wire

// *** logic/opaddr_pkg.sv ***
// Constants and types shared by the operand addressing unit
package opaddr_pkg;

   // ==========================================================
   // Register bus map, byte addresses of 32-bit words
   localparam logic [7:0] ADR_PC_LOW = 8'h00;
   localparam logic [7:0] ADR_PC_HIGH = 8'h04;
   localparam logic [7:0] ADR_CTRL = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0c;
   localparam logic [7:0] ADR_ACC = 8'h10;
   localparam logic [7:0] ADR_INDEX = 8'h14;
   localparam logic [7:0] ADR_FLAGS = 8'h18;
   localparam logic [7:0] ADR_STACK = 8'h1c;

   // Control register bits
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_CLR_ILL_BIT = 1;

   // ==========================================================
   // Core register reset values and flag layout
   localparam logic [7:0] PC_BYTE_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h02;
   localparam logic [7:0] FLAGS_WR_MASK = 8'h17;
   localparam int FLAG_BANK_BIT = 4;
   localparam logic [15:0] PC_STEP = 16'h0001;

   // ==========================================================
   // Opcode byte fields
   localparam int OPC_MODE_LSB = 0;
   localparam int OPC_SEL_LSB = 3;
   localparam int OPC_SPACE_BIT = 5;
   localparam int OPC_ALU_LSB = 6;

   typedef enum logic [2:0] {
      MODE_SRC_IMM = 3'h0,
      MODE_SRC_DIR = 3'h1,
      MODE_SRC_IDX = 3'h2,
      MODE_DST_DIR = 3'h3,
      MODE_DST_IDX = 3'h4,
      MODE_DST_DIR_IMM = 3'h5,
      MODE_RSV6 = 3'h6,
      MODE_RSV7 = 3'h7
   } addr_mode_t;

   typedef enum logic [1:0] {
      SEL_ACC = 2'h0,
      SEL_INDEX = 2'h1,
      SEL_FLAGS = 2'h2,
      SEL_STACK = 2'h3
   } reg_sel_t;

   typedef enum logic [1:0] {
      ALU_MOV = 2'h0,
      ALU_ADD = 2'h1,
      ALU_AND = 2'h2,
      ALU_OR = 2'h3
   } alu_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_OPCODE = 3'h1,
      ST_OPND1 = 3'h2,
      ST_OPND2 = 3'h3,
      ST_ADDR = 3'h4,
      ST_READ = 3'h5,
      ST_EXEC = 3'h6,
      ST_WRITE = 3'h7
   } state_t;

endpackage

// *** logic/operand_addr_gen.sv ***
// Operand address former: direct or indexed, RAM or register space
`timescale 1ns/100ps
`default_nettype none
module operand_addr_gen
   import opaddr_pkg::*;
(
   input wire logic [7:0] operand,
   input wire logic [7:0] indexVal,
   input wire logic useIndex,
   input wire logic spaceSel,
   input wire logic [7:0] flagsVal,
   output logic [7:0] addr,
   output logic regSpace,
   output logic bank
);

   // ==========================================================
   // Address sum
   logic [7:0] offset;
   assign offset = useIndex ? indexVal : DATA_RST;
   assign addr = operand + offset; // Eight bit sum wraps

   // ==========================================================
   // Space and bank selection
   assign regSpace = spaceSel;
   assign bank = spaceSel & flagsVal[FLAG_BANK_BIT];

endmodule // operand_addr_gen
`default_nettype wire

// *** logic/alu8.sv ***
// Eight bit operation unit for move, add, and, or
`timescale 1ns/100ps
`default_nettype none
module alu8
   import opaddr_pkg::*;
(
   input wire logic [1:0] op,
   input wire logic [7:0] srcVal,
   input wire logic [7:0] otherVal,
   output logic [7:0] result
);

   // ==========================================================
   // Operation results
   logic [7:0] sumVal;
   logic [7:0] andVal;
   logic [7:0] orVal;
   assign sumVal = srcVal + otherVal;
   assign andVal = srcVal & otherVal;
   assign orVal = srcVal | otherVal;

   // Result select
   assign result = (op == ALU_ADD) ? sumVal :
                   (op == ALU_AND) ? andVal :
                   (op == ALU_OR) ? orVal : srcVal;

endmodule // alu8
`default_nettype wire

// *** tb/operand_addressing_unit_chk.sv ***
// Port checker for the operand addressing unit
`timescale 1ns/100ps
`default_nettype none
module operand_addressing_unit_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck,
   input wire logic [15:0] fetchAddr,
   input wire logic fetchReq,
   input wire logic fetchAck,
   input wire logic [7:0] memAddr,
   input wire logic memRegSpace,
   input wire logic memBank,
   input wire logic memRe,
   input wire logic memWe,
   input wire logic [7:0] memWrData,
   input wire logic memAck
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ======================================
   // Bus, fetch and memory port relations
   property p_ackNext; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
   a_ackNext: assert property (p_ackNext) else $error("ack late");
   property p_ackPulse; wbAck |=> !wbAck; endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
   property p_pcStep; fetchReq && fetchAck |=> fetchAddr == $past(fetchAddr) + 16'h0001; endproperty
   a_pcStep: assert property (p_pcStep) else $error("pc not stepped");
   property p_pcHold; !(fetchReq && fetchAck) |=> $stable(fetchAddr); endproperty
   a_pcHold: assert property (p_pcHold) else $error("pc moved");
   property p_fetchHold; fetchReq && !fetchAck && !$past(fetchAck) |=> fetchReq; endproperty
   a_fetchHold: assert property (p_fetchHold) else $error("fetch dropped");
   property p_rdHold; memRe && !memAck |=> memRe && $stable(memAddr); endproperty
   a_rdHold: assert property (p_rdHold) else $error("read dropped");
   property p_wrHold; memWe && !memAck |=> memWe && $stable(memWrData) && $stable(memAddr); endproperty
   a_wrHold: assert property (p_wrHold) else $error("write dropped");
   property p_rdDone; memRe && memAck |=> !memRe; endproperty
   a_rdDone: assert property (p_rdDone) else $error("read kept");
   property p_bankRam; !memRegSpace |-> !memBank; endproperty
   a_bankRam: assert property (p_bankRam) else $error("bank in ram");
endmodule // operand_addressing_unit_chk
bind operand_addressing_unit operand_addressing_unit_chk i_operand_addressing_unit_chk (
   .clk(clk), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
   .fetchAddr(fetchAddr), .fetchReq(fetchReq), .fetchAck(fetchAck), .memAddr(memAddr),
   .memRegSpace(memRegSpace), .memBank(memBank), .memRe(memRe), .memWe(memWe),
   .memWrData(memWrData), .memAck(memAck));
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the operand addressing unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import opaddr_pkg::*;
;
   logic clk, arst_n, wbCyc, wbStb, wbWe, wbAck, fetchReq;
   logic memRegSpace, memBank, memRe, memWe;
   logic fetchAck = 1'b0;
   logic memAck = 1'b0;
   logic [7:0] wbAdr, memAddr, memWrData;
   logic [7:0] memRdData = 8'h00;
   logic [7:0] fetchData = 8'h00;
   logic [3:0] wbSel;
   logic [31:0] wbDatW, wbDatR;
   logic [15:0] fetchAddr;
   logic [7:0] prog[$];
   logic [7:0] dmem[768], expMem[768], mR[4];
   int failures, checked, lim;
   int fWait = 0;
   int mWait = 0;
   int seed = 32'hbf62;
   // ======================================
   // Clock, design and far side
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   operand_addressing_unit i_operand_addressing_unit (.clk(clk), .arst_n(arst_n),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .fetchAddr(fetchAddr),
      .fetchReq(fetchReq), .fetchData(fetchData), .fetchAck(fetchAck), .memAddr(memAddr),
      .memRegSpace(memRegSpace), .memBank(memBank), .memRe(memRe), .memWe(memWe),
      .memWrData(memWrData), .memRdData(memRdData), .memAck(memAck));
   function automatic int mi(logic rs, logic bk, logic [7:0] a);
      return rs ? 256 + 256 * bk + a : a;
   endfunction
   // Program store, answers after a random wait
   always @(posedge clk) begin
      if (fetchReq && !fetchAck && fetchAddr < lim && fWait == 0) begin
         fetchAck <= 1'b1;
         fetchData <= prog[fetchAddr];
         fWait <= $unsigned($random(seed)) % 3;
      end else begin
         fetchAck <= 1'b0;
         fetchData <= 8'($random(seed));
         if (fetchReq && fWait > 0) fWait <= fWait - 1;
      end
   end
   // Data store, idle read lines toggle
   always @(posedge clk) begin
      if ((memRe || memWe) && !memAck && mWait == 0) begin
         memAck <= 1'b1;
         memRdData <= dmem[mi(memRegSpace, memBank, memAddr)];
         if (memWe) dmem[mi(memRegSpace, memBank, memAddr)] = memWrData;
         mWait <= $unsigned($random(seed)) % 3;
      end else begin
         memAck <= 1'b0;
         memRdData <= ~memRdData;
         if ((memRe || memWe) && mWait > 0) mWait <= mWait - 1;
      end
   end
   // ======================================
   // Tasks
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 20) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic regsCheck();
      logic [31:0] q;
      for (int k = 0; k < 4; k++) begin
         xfer(1'b0, ADR_ACC + 8'(4 * k), 32'h0, q);
         chk("core reg", {24'h0, mR[k]}, q);
      end
      xfer(1'b0, ADR_PC_LOW, 32'h0, q);
      chk("pc low", {24'h0, lim[7:0]}, q);
      xfer(1'b0, ADR_PC_HIGH, 32'h0, q);
      chk("pc high", {24'h0, lim[15:8]}, q);
   endtask
   // Model one instruction, run it, compare every result
   task automatic ins(input int md, input int op, input int sel, input logic rs,
         input logic [7:0] o1);
      logic [7:0] o2, ad, src, oth, res;
      int i, n, r;
      o2 = 8'($random(seed));
      r = (md == 0) ? sel : sel % 2;
      prog.push_back({op[1:0], rs, sel[1:0], md[2:0]});
      if (md < 6) prog.push_back(o1);
      if (md == 5) prog.push_back(o2);
      ad = (md == 2 || md == 4) ? o1 + mR[1] : o1;
      i = mi(rs, mR[2][FLAG_BANK_BIT], ad);
      src = (md == 0) ? o1 : (md < 3) ? expMem[i] : (md == 3) ? mR[r] : (md == 4) ? mR[0] : o2;
      oth = (md < 3) ? mR[r] : expMem[i];
      res = (op == 0) ? src : (op == 1) ? src + oth : (op == 2) ? (src & oth) : (src | oth);
      if (md == 0 && r == 2) mR[2] = (mR[2] & ~FLAGS_WR_MASK) | (res & FLAGS_WR_MASK);
      else if (md < 3) mR[r] = res;
      else if (md < 6) expMem[i] = res;
      lim = prog.size();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(fetchReq === 1'b1 && fetchAddr === lim[15:0]) && n < 300);
      if (n >= 300) begin
         failures++;
         stop_test();
      end
      regsCheck();
      chk("memory", {24'h0, expMem[i]}, {24'h0, dmem[i]});
   endtask
   task automatic sweep();
      for (int md = 0; md < 6; md++) begin
         for (int op = 0; op < 4; op++) begin
            ins(md, op, $unsigned($random(seed)) % 4, 1'($random(seed)), 8'($random(seed)));
         end
      end
   endtask
   // ======================================
   // Main sequence
   initial begin
      logic [31:0] q;
      {arst_n, wbCyc, wbStb, wbWe} = '0;
      {wbAdr, wbDatW} = '0;
      wbSel = 4'hf;
      lim = 0;
      for (int k = 0; k < 768; k++) begin
         dmem[k] = 8'($random(seed));
         expMem[k] = dmem[k];
      end
      mR = '{8'h00, 8'h00, FLAGS_RST, 8'h00};
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      regsCheck();
      xfer(1'b1, ADR_PC_LOW, 32'hff, q);
      xfer(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", 32'h0, q);
      regsCheck();
      xfer(1'b1, ADR_CTRL, 32'h1, q);
      ins(6, 0, 2, 1'b0, 8'h00);
      xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk("illegal set", 32'h8, q & 32'h8);
      xfer(1'b1, ADR_CTRL, 32'h3, q);
      xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk("illegal clear", 32'h0, q & 32'h8);
      ins(0, 3, 2, 1'b0, 8'h10);
      sweep();
      ins(0, 2, 2, 1'b0, 8'hef);
      sweep();
      ins(7, 1, 0, 1'b1, 8'h00);
      xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk("illegal", 32'h8, q & 32'h8);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
